// ==== verilog/tcp_pkg.sv ====
// package: register map, field positions, reset values and timing constants of the timer
package tcp_pkg;
   // byte addresses on the apb bus
   localparam logic [11:0] TCP_COUNT_OFS  = 12'h000;
   localparam logic [11:0] TCP_OPTION_OFS = 12'h004;
   localparam logic [11:0] TCP_INTCTL_OFS = 12'h008;
   localparam logic [11:0] TCP_CMD_OFS    = 12'h00C;
   localparam logic [11:0] TCP_STATUS_OFS = 12'h010;
   // option register fields
   localparam int TCP_CSS_BIT  = 5;
   localparam int TCP_SES_BIT  = 4;
   localparam int TCP_PSA_BIT  = 3;
   localparam int TCP_PSR_LSB  = 0;
   localparam logic [7:0] TCP_OPTION_RST = 8'hFF;
   // interrupt control register fields
   localparam int TCP_OIE_BIT  = 5;
   localparam int TCP_OVF_BIT  = 2;
   localparam logic [7:0] TCP_INTCTL_RST = 8'h00;
   // command register: write one to pulse
   localparam int TCP_CMD_WDCLR_BIT = 0;
   localparam int TCP_CMD_SLEEP_BIT = 1;
   localparam int TCP_CMD_WAKE_BIT  = 2;
   localparam logic [7:0] TCP_COUNT_RST = 8'h00;
   // write inhibit length in instruction cycles
   localparam logic [1:0] TCP_WR_INHIBIT = 2'h2;
   // instruction cycle phases: four core clocks per instruction cycle
   localparam logic [1:0] TCP_PH_TWO  = 2'h1;
   localparam logic [1:0] TCP_PH_FOUR = 2'h3;
   localparam logic [7:0] TCP_PRE_RST = 8'h00;
endpackage

// ==== verilog/tcp_sync2.sv ====
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module tcp_sync2 (
   input  wire logic core_clk_in,
   input  wire logic arst_n_in,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule

// ==== verilog/tcp_timer.sv ====
// timer/counter with shared prescaler, apb register slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - clock source select clear: timer counts instruction cycles, each one directly when the prescaler goes to the watchdog
// - any count register write blocks incrementing for the next two instruction cycles
// - clock source select set: count external edges, edge select clear means rising
// - prescaler assign clear gives prescaler to timer, set gives it to watchdog
// - with timer assignment ratio field picks power of two from 1:2 to 1:256
// - prescaler is an 8-bit counter software cannot read or write
// - wrap of count register from FFh to 00h sets the overflow flag
// - interrupt masked while enable clear; software clears flag before re-enabling
// - timer halts in sleep, so overflow never wakes the processor
// - external path sampled on phase two and phase four of each instruction cycle
// - count increments a short synchronisation delay after the external edge
// - with timer assignment every count register write clears the prescaler
// - with watchdog assignment watchdog clear also clears the prescaler
// - any reset loads all ones into the option register
module tcp_timer
   import tcp_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_count_input_in,
   output logic             overflow_irq_out,
   output logic             watchdog_tick_out,
   output logic             watchdog_clear_out
);
   logic ext_sync;
   // the pin goes through two flops before any edge logic looks at it
   tcp_sync2 u_sync (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .async_in    (external_count_input_in),
      .sync_out    (ext_sync)
   );

   logic [7:0]  count_register_reg, count_register_next;
   logic [7:0]  option_reg, option_next;
   logic [7:0]  intctl_reg, intctl_next;
   logic [7:0]  pre_reg, pre_next;
   logic [1:0]  phase_reg, phase_next;
   logic [1:0]  inhibit_reg, inhibit_next;
   logic        sleep_reg, sleep_next;
   logic        ext_prev_reg, ext_prev_next;
   logic        samp_reg, samp_next;
   logic        samp_prev_reg, samp_prev_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic        irq_reg, irq_next;
   logic        wdt_tick_reg, wdt_tick_next;
   logic        wdt_clr_reg, wdt_clr_next;

   logic       clock_source_select;
   logic       source_edge_select;
   logic       prescaler_assign;
   logic [2:0] prescale_ratio;
   logic       wr_access;
   logic       rd_access;
   logic       wr_count;
   logic       wr_cmd;
   logic       cyc_end;
   logic       src_edge;
   logic       pre_out;
   logic       pre_out_next;
   logic       inc_event;
   logic       wd_clear_cmd;

   assign clock_source_select = option_reg[TCP_CSS_BIT];
   assign source_edge_select  = option_reg[TCP_SES_BIT];
   assign prescaler_assign    = option_reg[TCP_PSA_BIT];
   assign prescale_ratio      = option_reg[TCP_PSR_LSB +: 3];

   // apb: access phase with one wait state, pready registered at the first edge with penable high
   assign wr_access    = psel && penable && pwrite && !pready_reg;
   assign rd_access    = psel && penable && !pwrite && !pready_reg;
   assign wr_count     = wr_access && (paddr == TCP_COUNT_OFS);
   assign wr_cmd       = wr_access && (paddr == TCP_CMD_OFS);
   assign wd_clear_cmd = wr_cmd && pwdata[TCP_CMD_WDCLR_BIT];
   assign cyc_end      = (phase_reg == TCP_PH_FOUR);

   // instruction cycle phase counter, stopped in sleep
   always_comb begin
      phase_next = sleep_reg ? phase_reg : phase_reg + 2'h1;
   end

   // edge detect on the synchronised pin; xor with edge select picks the polarity
   always_comb begin
      ext_prev_next = ext_sync;
      src_edge = clock_source_select ?
                 ((ext_sync ^ source_edge_select) && !(ext_prev_reg ^ source_edge_select))
                 : cyc_end;
   end

   // prescaler: 8-bit counter, output is the bit chosen by the ratio field
   always_comb begin
      pre_next = pre_reg;
      if (!sleep_reg && src_edge && !prescaler_assign) begin
         pre_next = pre_reg + 8'h01;
      end
      if (prescaler_assign && !sleep_reg && cyc_end) begin
         pre_next = pre_reg + 8'h01;
      end
      if (wr_count && !prescaler_assign) begin
         pre_next = TCP_PRE_RST;
      end
      if (wd_clear_cmd && prescaler_assign) begin
         pre_next = TCP_PRE_RST;
      end
      pre_out      = pre_reg[prescale_ratio];
      pre_out_next = pre_next[prescale_ratio];
   end

   // sample the prescaler output, or the pin itself with watchdog assignment, on phase two and phase four
   always_comb begin
      samp_next      = samp_reg;
      samp_prev_next = samp_prev_reg;
      if (phase_reg == TCP_PH_TWO || phase_reg == TCP_PH_FOUR) begin
         // sample a level, never a one-clock pulse, so no edge falls between samples
         samp_next      = prescaler_assign ? (ext_sync ^ source_edge_select) : pre_out;
         samp_prev_next = samp_reg;
      end
   end

   // increment source: delayed by the sampler in counter mode
   always_comb begin
      if (prescaler_assign && !clock_source_select) begin
         inc_event = cyc_end;
      end else begin
         // every pair of consecutive samples is looked at once, on the sample after the later one
         inc_event = (phase_reg == TCP_PH_TWO || phase_reg == TCP_PH_FOUR) &&
                     samp_reg && !samp_prev_reg;
      end
   end

   // count register, write inhibit and overflow flag
   always_comb begin
      count_register_next = count_register_reg;
      inhibit_next        = inhibit_reg;
      intctl_next         = intctl_reg;
      if (cyc_end && inhibit_reg != 2'h0) begin
         inhibit_next = inhibit_reg - 2'h1;
      end
      if (!sleep_reg && inc_event && inhibit_reg == 2'h0) begin
         count_register_next = count_register_reg + 8'h01;
      end
      if (wr_access && paddr == TCP_INTCTL_OFS) begin
         intctl_next = pwdata[7:0];
      end
      // set wins over a software clear in the same cycle
      if (!sleep_reg && inc_event && inhibit_reg == 2'h0 &&
          count_register_reg == 8'hFF) begin
         intctl_next[TCP_OVF_BIT] = 1'b1;
      end
      if (wr_count) begin
         count_register_next = pwdata[7:0];
         inhibit_next        = TCP_WR_INHIBIT;
      end
   end

   // option register, sleep control and bus answer
   always_comb begin
      option_next   = option_reg;
      sleep_next    = sleep_reg;
      pready_next   = psel && penable && !pready_reg;
      pslverr_next  = 1'b0;
      prdata_next   = 32'h0000_0000;
      if (wr_access && paddr == TCP_OPTION_OFS) begin
         option_next = pwdata[7:0];
      end
      if (wr_cmd && pwdata[TCP_CMD_SLEEP_BIT]) begin
         sleep_next = 1'b1;
      end
      if (wr_cmd && pwdata[TCP_CMD_WAKE_BIT]) begin
         sleep_next = 1'b0;
      end
      if (rd_access) begin
         unique case (paddr)
            TCP_COUNT_OFS:  prdata_next = {24'h000000, count_register_reg};
            TCP_OPTION_OFS: prdata_next = {24'h000000, option_reg};
            TCP_INTCTL_OFS: prdata_next = {24'h000000, intctl_reg};
            TCP_CMD_OFS:    prdata_next = 32'h0000_0000;
            TCP_STATUS_OFS: prdata_next = {29'h0, inhibit_reg != 2'h0, sleep_reg, ext_sync};
            default:        pslverr_next = 1'b1;
         endcase
      end else if (wr_access && !(paddr == TCP_COUNT_OFS || paddr == TCP_OPTION_OFS ||
                                  paddr == TCP_INTCTL_OFS || paddr == TCP_CMD_OFS)) begin
         pslverr_next = 1'b1;
      end
      irq_next      = intctl_next[TCP_OVF_BIT] && intctl_next[TCP_OIE_BIT];
      wdt_tick_next = prescaler_assign ? (pre_out_next && !pre_out) : cyc_end;
      wdt_clr_next  = wd_clear_cmd;
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_register_reg <= TCP_COUNT_RST;
         option_reg         <= TCP_OPTION_RST;
         intctl_reg         <= TCP_INTCTL_RST;
         pre_reg            <= TCP_PRE_RST;
         phase_reg          <= 2'h0;
         inhibit_reg        <= 2'h0;
         sleep_reg          <= 1'b0;
         ext_prev_reg       <= 1'b0;
         samp_reg           <= 1'b0;
         samp_prev_reg      <= 1'b0;
         prdata_reg         <= 32'h0000_0000;
         pready_reg         <= 1'b0;
         pslverr_reg        <= 1'b0;
         irq_reg            <= 1'b0;
         wdt_tick_reg       <= 1'b0;
         wdt_clr_reg        <= 1'b0;
      end else begin
         count_register_reg <= count_register_next;
         option_reg         <= option_next;
         intctl_reg         <= intctl_next;
         pre_reg            <= pre_next;
         phase_reg          <= phase_next;
         inhibit_reg        <= inhibit_next;
         sleep_reg          <= sleep_next;
         ext_prev_reg       <= ext_prev_next;
         samp_reg           <= samp_next;
         samp_prev_reg      <= samp_prev_next;
         prdata_reg         <= prdata_next;
         pready_reg         <= pready_next;
         pslverr_reg        <= pslverr_next;
         irq_reg            <= irq_next;
         wdt_tick_reg       <= wdt_tick_next;
         wdt_clr_reg        <= wdt_clr_next;
      end
   end

   assign prdata             = prdata_reg;
   assign pready             = pready_reg;
   assign pslverr            = pslverr_reg;
   assign overflow_irq_out   = irq_reg;
   assign watchdog_tick_out  = wdt_tick_reg;
   assign watchdog_clear_out = wdt_clr_reg;

   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);

   ovf_flag_set_a: assert property (
      (!sleep_reg && inc_event && inhibit_reg == 2'h0 && count_register_reg == 8'hFF && !wr_count)
      |=> (count_register_reg == 8'h00) && intctl_reg[TCP_OVF_BIT])
      else $error("overflow did not wrap and set the flag");
   wr_inhibit_a: assert property (
      wr_count |=> (inhibit_reg == TCP_WR_INHIBIT) ##1 $stable(count_register_reg) [*3])
      else $error("count moved inside write inhibit");
   sleep_hold_a: assert property (
      (sleep_reg && !wr_count) |=> $stable(count_register_reg))
      else $error("count moved during sleep");
   irq_mask_a: assert property (
      !intctl_reg[TCP_OIE_BIT] |-> !irq_reg)
      else $error("interrupt not masked");
   pre_wr_clear_a: assert property (
      (wr_count && !prescaler_assign) |=> pre_reg == TCP_PRE_RST)
      else $error("count write did not clear prescaler");
   pre_wd_clear_a: assert property (
      (wd_clear_cmd && prescaler_assign) |=> pre_reg == TCP_PRE_RST && wdt_clr_reg)
      else $error("watchdog clear did not clear prescaler");
   timer_rate_a: assert property (
      (prescaler_assign && !clock_source_select && !sleep_reg && inhibit_reg == 2'h0 &&
       cyc_end && !wr_count) |=> count_register_reg == $past(count_register_reg) + 8'h01)
      else $error("timer mode missed an instruction cycle");
   apb_answer_a: assert property (
      (psel && !penable) ##1 (psel && penable) |=> pready_reg)
      else $error("apb access not answered in one cycle");

   ovf_c:    cover property (intctl_reg[TCP_OVF_BIT] && irq_reg);
   ext_c:    cover property (clock_source_select && inc_event);
   presc_c:  cover property (!prescaler_assign && inc_event);
   sleep_c:  cover property (sleep_reg ##1 !sleep_reg);
endmodule

// ==== tb/tcp_count_src.sv ====
// external count source that drives the count pin with legal level times
`timescale 1ns/1ps
module tcp_count_src (
   input  wire logic core_clk_in,
   output logic      pin_out
);
   initial pin_out = 1'b0;
   // each level stands six core clocks, well above the two the sampler needs
   task automatic toggle(int n);
      repeat (n) begin
         @(posedge core_clk_in);
         pin_out <= ~pin_out;
         repeat (5) @(posedge core_clk_in);
      end
   endtask
endmodule

// ==== tb/timer_counter_shared_prescaler_bench.sv ====
// self-checking bench for the timer with shared prescaler
`timescale 1ns/1ps
module timer_counter_shared_prescaler_bench;
   import tcp_pkg::*;
   typedef struct {int kind; logic [7:0] val; logic err;} tcp_note_t;
   logic        core_clk_in = 1'b0;
   logic        arst_n_in   = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h00000000;
   logic [31:0] prdata;
   logic        pready, pslverr, pin, irq, tick, wdclr;
   int          miscompares = 0;
   int          cmp_count   = 0;
   int          cyc         = 0;
   logic [7:0]  last_rd     = 8'h00;
   logic [7:0]  v;
   tcp_note_t   nt;
   tcp_note_t   notes[$];

   tcp_timer uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_count_input_in(pin),
      .overflow_irq_out(irq), .watchdog_tick_out(tick), .watchdog_clear_out(wdclr));
   tcp_count_src src (.core_clk_in(core_clk_in), .pin_out(pin));

   initial begin
      forever #20 core_clk_in = ~core_clk_in;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (exp !== got) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // kind 0 only records the value, 1 compares it, 2 compares the change since the last read
   task automatic xfer(logic wr, logic [11:0] a, logic [7:0] d, int kind, logic [7:0] e,
                       logic err);
      int n;
      notes.push_back('{kind, e, err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge core_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         final_report();
      end
      // let an edge pass so the next setup never reassigns psel in this time step
      @(posedge core_clk_in);
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      xfer(1'b1, a, d, 0, 8'h00, 1'b0);
   endtask
   task automatic rd(logic [11:0] a, int kind, logic [7:0] e);
      xfer(1'b0, a, 8'h00, kind, e, 1'b0);
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // two count reads that start exactly d clocks apart
   task automatic rate(int d, logic [7:0] delta);
      int t;
      t = cyc;
      rd(TCP_COUNT_OFS, 0, 8'h00);
      while (cyc < t + d) @(posedge core_clk_in);
      rd(TCP_COUNT_OFS, 2, delta);
   endtask

   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (notes.size() == 0) check("transfer count", 8'h00, 8'h01);
         else begin
            nt = notes.pop_front();
            check("pslverr", {7'h00, nt.err}, {7'h00, pslverr});
            if (nt.kind == 1) check("read data", nt.val, prdata[7:0]);
            if (nt.kind == 2) check("count change", nt.val, prdata[7:0] - last_rd);
            if (pwrite === 1'b0) check("upper read bits", 8'h00, prdata[31:24] | prdata[15:8]);
            if (pwrite === 1'b0) last_rd = prdata[7:0];
         end
      end
   end

   initial begin
      void'($urandom(32'h94bb960a));
      idle(2);
      arst_n_in <= 1'b1;
      rd(TCP_OPTION_OFS, 1, TCP_OPTION_RST);
      rd(TCP_INTCTL_OFS, 1, TCP_INTCTL_RST);
      xfer(1'b0, 12'h014, 8'h00, 1, 8'h00, 1'b1);
      wr(TCP_OPTION_OFS, 8'h08);
      rate(40, 8'h0A);
      v = 8'($urandom_range(0, 250));
      wr(TCP_COUNT_OFS, v);
      rd(TCP_COUNT_OFS, 1, v);
      for (int r = 0; r < 8; r++) begin
         wr(TCP_CMD_OFS, 8'h01);
         wr(TCP_OPTION_OFS, 8'(r));
         wr(TCP_COUNT_OFS, 8'h00);
         idle(16);
         rate(16 << r, 8'h02);
      end
      // with 1:256 each write clears the prescaler, so 300 cycles in total never count
      repeat (3) begin
         wr(TCP_COUNT_OFS, 8'h40);
         idle(400);
      end
      rd(TCP_COUNT_OFS, 1, 8'h40);
      wr(TCP_CMD_OFS, 8'h01);
      wr(TCP_COUNT_OFS, 8'h00);
      wr(TCP_OPTION_OFS, 8'h2F);
      wr(TCP_CMD_OFS, 8'h01);
      wr(TCP_OPTION_OFS, 8'h08);
      wr(TCP_INTCTL_OFS, 8'h20);
      wr(TCP_COUNT_OFS, 8'hFF);
      idle(40);
      check("overflow irq", 8'h01, {7'h00, irq});
      rd(TCP_INTCTL_OFS, 1, 8'h24);
      wr(TCP_INTCTL_OFS, 8'h04);
      idle(2);
      check("masked irq", 8'h00, {7'h00, irq});
      wr(TCP_INTCTL_OFS, 8'h00);
      rd(TCP_INTCTL_OFS, 1, 8'h00);
      wr(TCP_CMD_OFS, 8'h02);
      rate(200, 8'h00);
      wr(TCP_CMD_OFS, 8'h04);
      rate(40, 8'h0A);
      for (int s = 0; s < 2; s++) begin
         wr(TCP_OPTION_OFS, 8'h28 | 8'(s << 4));
         idle(8);
         for (int k = 0; k < 2; k++) begin
            rd(TCP_COUNT_OFS, 0, 8'h00);
            src.toggle(1);
            idle(40);
            rd(TCP_COUNT_OFS, 2, (k == s) ? 8'h01 : 8'h00);
         end
      end
      wr(TCP_OPTION_OFS, 8'h20);
      wr(TCP_COUNT_OFS, 8'h00);
      idle(16);
      rd(TCP_COUNT_OFS, 0, 8'h00);
      src.toggle(8);
      idle(40);
      rd(TCP_COUNT_OFS, 2, 8'h02);
      final_report();
   end
endmodule
